/* verilog/tmr_cfg.svh */
// Behaviour
// - select n divides timer 2^(n+1), watchdog 2^n
// - assign bit routes prescaler to timer or watchdog
// - edge-select picks rising or falling input edge
// - source-select picks cycle clock or input pin
// - interrupt enable set/cleared by instructions only
// - active-low pull-up enable for wake-capable pins
// - timer write clears prescaler when timer-assigned
// - watchdog-clear and sleep clear watchdog, maybe prescaler
// - eight-bit timer counts one per prescaler output, per source tick if unprescaled
// - watchdog free-runs, time-out resets device
// - unprescaled watchdog period about 18 ms
// - fuse gates watchdog-enable bit
// - direction bit one means input, zero output
// - small variant keeps only low port-5 direction bits
// - open-drain bit makes upper port-7 pins open-drain
// - sleep-control falling stops oscillator, rising wakes
// - hardware sets sleep-control at wake, software clears
// - start-up delay of 18 ms after wake
// - wake from oscillator stop re-enables watchdog by fuse
// - resistor option reads low port-7 pins
// - active-low wake-up enable for wake-capable pins
// - mask bit 0 overflow, bit 3 external pin
// - overflow flag sticky until software clears
// - option register resets to ones except bit 6
// - control register resets to 8'h31
// - flags and masks reset cleared
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH

// ===========================================================
// register selects for the core's move instructions
`define SEL_OPTION   3'h0
`define SEL_PORT5DIR 3'h1
`define SEL_PORT6DIR 3'h2
`define SEL_PORT7DIR 3'h3
`define SEL_WDCTRL   3'h4
`define SEL_IRQMASK  3'h5
`define SEL_TIMER    3'h6
`define SEL_IRQFLAG  3'h7

// ===========================================================
// field positions
`define OPT_PSEL_LO  0
`define OPT_ASSIGN   3
`define OPT_EDGE     4
`define OPT_SOURCE   5
`define OPT_GIE      6
`define OPT_PULLUPN  7
`define WD_WAKEN     0
`define WD_ROC       3
`define WD_SLEEP     4
`define WD_ENABLE    5
`define WD_ODE       6
`define IRQ_OVF      0
`define IRQ_EXT      3

// ===========================================================
// reset values and masks
`define OPTION_RESET 8'hBF
`define WDCTRL_RESET 8'h31
`define WDCTRL_MASK  8'h79
`define IRQ_MASK     8'h09
`define DIR_RESET    8'hFF
`define PORT5_SMALL  8'h0F

// ===========================================================
// timing
`define CLK_PERIOD_NS 50
`define WDT_PERIOD_US 18000
`define OST_PERIOD_US 18000

`endif

/* verilog/tmr_pkg.sv */
`default_nettype none
package tmr_pkg;
  typedef enum logic [1:0] {
    ST_RUN,
    ST_OSC_STOP,
    ST_STARTUP
  } osc_state_t;
endpackage : tmr_pkg
`default_nettype wire

/* verilog/timer_watchdog_port_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tmr_cfg.svh"
module timer_watchdog_port_ctrl
  import tmr_pkg::*;
#(
  parameter int  WDT_CYCLES   = (`WDT_PERIOD_US * 1000) / `CLK_PERIOD_NS,
  parameter int  OST_CYCLES   = (`OST_PERIOD_US * 1000) / `CLK_PERIOD_NS,
  parameter bit  SMALL_VARIANT = 1'b1
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // core register access
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [2:0] regSel,
  input  wire logic [7:0] wrData,
  output logic      [7:0] rdData,
  // core instruction strobes
  input  wire logic       irqOnInstr,
  input  wire logic       irqOffInstr,
  input  wire logic       irqReturnInstr,
  input  wire logic       irqEntry,
  input  wire logic       watchdogClearInstr,
  input  wire logic       sleepInstr,
  // code option
  input  wire logic       watchdogFuse,
  // pins
  input  wire logic       timerPin,
  input  wire logic       extIrqPinN,
  input  wire logic [7:0] port6Pins,
  input  wire logic [7:0] port7Pins,
  input  wire logic [1:0] port7OdData,
  // pin controls
  output logic      [7:0] port5Oe,
  output logic      [7:0] port6Oe,
  output logic      [7:0] port7Oe,
  output logic            pullupOn,
  output logic            wakeArmed,
  output logic      [1:0] resistorOptionRead,
  // system
  output logic            irqRequest,
  output logic            watchdogReset,
  output logic            oscStop,
  output logic            coreHold
);

  // =========================================================
  // registers and synchronisers
  logic [7:0] timerOption;
  logic [7:0] port5Direction;
  logic [7:0] port6Direction;
  logic [7:0] port7Direction;
  logic [7:0] watchdogSleepCtrl;
  logic [7:0] irqMask;
  logic [7:0] irqFlags;
  logic [7:0] timerCounter;
  logic [7:0] prescaler;
  logic [31:0] watchdogTimer;
  logic [31:0] ostCount;
  osc_state_t oscState;
  logic [2:0] tmrSync;
  logic [2:0] intSync;
  logic [9:0] wakeMeta;
  logic [9:0] wakeSync;
  logic [9:0] wakePrev;
  logic [1:0] ropMeta;
  logic [1:0] ropSync;
  logic       sleepPrev;

  function automatic logic [7:0] divMask(input logic [2:0] sel,
                                         input logic forTimer);
    logic [8:0] span;
    span = forTimer ? (9'h002 << sel) : (9'h001 << sel);
    divMask = span[7:0] - 8'h01;
  endfunction : divMask

  // =========================================================
  // decode
  logic       toWatchdog;
  logic       wdEnabled;
  logic       running;
  logic       extEdge;
  logic       timerSrcTick;
  logic       wdBaseTick;
  logic       preSrc;
  logic       preOut;
  logic       timerTick;
  logic       wdTick;
  logic       timerWrite;
  logic       ovfSet;
  logic       extSet;
  logic       wakeEvent;
  logic [7:0] p5Mask;
  logic [7:0] preMask;

  assign toWatchdog = timerOption[`OPT_ASSIGN];
  assign wdEnabled  = watchdogFuse & watchdogSleepCtrl[`WD_ENABLE];
  assign running    = (oscState == ST_RUN);
  // edge seen on the two synchronised stages only
  assign extEdge    = timerOption[`OPT_EDGE] ?
                      (tmrSync[2] & ~tmrSync[1]) :
                      (~tmrSync[2] & tmrSync[1]);
  // internal source halts while the oscillator is stopped
  assign timerSrcTick = timerOption[`OPT_SOURCE] ? extEdge : running;
  assign wdBaseTick = wdEnabled &&
                      (watchdogTimer == 32'(WDT_CYCLES - 1));
  assign preSrc     = toWatchdog ? wdBaseTick : timerSrcTick;
  assign preMask    = divMask(timerOption[2:0], ~toWatchdog);
  assign preOut     = preSrc && ((prescaler & preMask) == preMask);
  assign timerTick  = toWatchdog ? timerSrcTick : preOut;
  assign wdTick     = toWatchdog ? preOut : wdBaseTick;
  assign timerWrite = regWrite && (regSel == `SEL_TIMER);
  assign ovfSet     = timerTick && !timerWrite && (timerCounter == 8'hFF);
  assign extSet     = intSync[2] & ~intSync[1];
  // pin change on port 6 and the two pull-up pins of port 7
  assign wakeEvent  = !watchdogSleepCtrl[`WD_WAKEN] &&
                      (wakeSync != wakePrev);
  assign p5Mask     = SMALL_VARIANT ? `PORT5_SMALL : 8'hFF;

  // =========================================================
  // pin synchronisers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tmrSync  <= 3'h0;
      intSync  <= 3'h7;
      // wake pins idle high, so no false change follows reset
      wakeMeta <= 10'h3FF;
      wakeSync <= 10'h3FF;
      wakePrev <= 10'h3FF;
      ropMeta  <= 2'h0;
      ropSync  <= 2'h0;
    end else begin
      tmrSync  <= {tmrSync[1:0], timerPin};
      intSync  <= {intSync[1:0], extIrqPinN};
      wakeMeta <= {port7Pins[5:4], port6Pins};
      wakeSync <= wakeMeta;
      wakePrev <= wakeSync;
      ropMeta  <= port7Pins[1:0];
      ropSync  <= ropMeta;
    end
  end

  // =========================================================
  // option register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timerOption <= `OPTION_RESET;
    end else begin
      if (regWrite && regSel == `SEL_OPTION) begin
        // the option write leaves the interrupt enable alone
        timerOption[5:0] <= wrData[5:0];
        timerOption[`OPT_PULLUPN] <= wrData[`OPT_PULLUPN];
      end
      if (irqEntry || irqOffInstr) begin
        timerOption[`OPT_GIE] <= 1'b0;
      end else if (irqOnInstr || irqReturnInstr) begin
        timerOption[`OPT_GIE] <= 1'b1;
      end
    end
  end

  // =========================================================
  // direction, mask and control registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      port5Direction <= `DIR_RESET;
      port6Direction <= `DIR_RESET;
      port7Direction <= `DIR_RESET;
      irqMask        <= 8'h00;
    end else if (regWrite) begin
      case (regSel)
        `SEL_PORT5DIR: port5Direction <= wrData | ~p5Mask;
        `SEL_PORT6DIR: port6Direction <= wrData;
        `SEL_PORT7DIR: port7Direction <= wrData;
        `SEL_IRQMASK:  irqMask <= wrData & `IRQ_MASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      watchdogSleepCtrl <= `WDCTRL_RESET;
    end else begin
      if (regWrite && regSel == `SEL_WDCTRL) begin
        watchdogSleepCtrl <= wrData & `WDCTRL_MASK;
      end
      // wake sets the bit, and the set wins over a clearing write
      if (oscState == ST_OSC_STOP && wakeEvent) begin
        watchdogSleepCtrl[`WD_SLEEP] <= 1'b1;
      end
      if (oscState == ST_STARTUP && ostCount == 32'h0) begin
        watchdogSleepCtrl[`WD_ENABLE] <= watchdogFuse;
      end
    end
  end

  // =========================================================
  // interrupt flags
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irqFlags <= 8'h00;
    end else begin
      if (regWrite && regSel == `SEL_IRQFLAG) begin
        // software may only clear
        irqFlags <= irqFlags & wrData & `IRQ_MASK;
      end
      if (ovfSet) begin
        irqFlags[`IRQ_OVF] <= 1'b1;
      end
      if (extSet) begin
        irqFlags[`IRQ_EXT] <= 1'b1;
      end
    end
  end

  // =========================================================
  // timer and prescaler
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timerCounter <= 8'h00;
    end else if (timerWrite) begin
      timerCounter <= wrData;
    end else if (timerTick) begin
      timerCounter <= timerCounter + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prescaler <= 8'h00;
    end else if (timerWrite && !toWatchdog) begin
      prescaler <= 8'h00;
    end else if ((watchdogClearInstr || sleepInstr) && toWatchdog) begin
      prescaler <= 8'h00;
    end else if (preSrc) begin
      prescaler <= prescaler + 8'h01;
    end
  end

  // =========================================================
  // watchdog: counts on every rising edge while enabled, asleep or not
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      watchdogTimer <= 32'h0;
    end else if (watchdogClearInstr || sleepInstr || !wdEnabled
                 || wdBaseTick) begin
      watchdogTimer <= 32'h0;
    end else begin
      watchdogTimer <= watchdogTimer + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      watchdogReset <= 1'b0;
    end else begin
      watchdogReset <= wdTick && !watchdogClearInstr && !sleepInstr;
    end
  end

  // =========================================================
  // oscillator stop and wake
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sleepPrev <= 1'b1;
      oscState  <= ST_RUN;
      ostCount  <= 32'h0;
    end else begin
      sleepPrev <= watchdogSleepCtrl[`WD_SLEEP];
      case (oscState)
        ST_RUN: begin
          if (sleepPrev && !watchdogSleepCtrl[`WD_SLEEP]) begin
            oscState <= ST_OSC_STOP;
          end
        end
        ST_OSC_STOP: begin
          if (!sleepPrev && watchdogSleepCtrl[`WD_SLEEP]) begin
            oscState <= ST_STARTUP;
            ostCount <= 32'(OST_CYCLES - 1);
          end
        end
        ST_STARTUP: begin
          if (ostCount == 32'h0) begin
            oscState <= ST_RUN;
          end else begin
            ostCount <= ostCount - 32'h1;
          end
        end
        default: oscState <= ST_RUN;
      endcase
    end
  end

  // =========================================================
  // registered outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      port5Oe            <= 8'h00;
      port6Oe            <= 8'h00;
      port7Oe            <= 8'h00;
      pullupOn           <= 1'b0;
      wakeArmed          <= 1'b0;
      resistorOptionRead <= 2'h0;
      irqRequest         <= 1'b0;
      oscStop            <= 1'b0;
      coreHold           <= 1'b0;
    end else begin
      port5Oe   <= ~port5Direction & p5Mask;
      port6Oe   <= ~port6Direction;
      port7Oe[5:0] <= ~port7Direction[5:0];
      // open drain drives low only
      port7Oe[7:6] <= ~port7Direction[7:6] &
                      (watchdogSleepCtrl[`WD_ODE] ?
                       ~port7OdData : 2'h3);
      pullupOn  <= ~timerOption[`OPT_PULLUPN];
      wakeArmed <= ~watchdogSleepCtrl[`WD_WAKEN];
      resistorOptionRead <= watchdogSleepCtrl[`WD_ROC] ?
                            ropSync : 2'h0;
      irqRequest <= timerOption[`OPT_GIE] &&
                    |(irqFlags & irqMask);
      oscStop   <= (oscState == ST_OSC_STOP);
      coreHold  <= (oscState != ST_RUN);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdData <= 8'h00;
    end else if (regRead) begin
      case (regSel)
        `SEL_OPTION:   rdData <= timerOption;
        `SEL_PORT5DIR: rdData <= port5Direction & p5Mask;
        `SEL_PORT6DIR: rdData <= port6Direction;
        `SEL_PORT7DIR: rdData <= port7Direction;
        `SEL_WDCTRL:   rdData <= watchdogSleepCtrl;
        `SEL_IRQMASK:  rdData <= irqMask;
        `SEL_TIMER:    rdData <= timerCounter;
        `SEL_IRQFLAG:  rdData <= irqFlags & irqMask;
        default:       rdData <= 8'h00;
      endcase
    end
  end

  // =========================================================
  // checks
  property p_gie_keep;
    @(posedge clk) disable iff (!resetn)
    (regWrite && regSel == `SEL_OPTION && !irqOnInstr && !irqOffInstr
     && !irqReturnInstr && !irqEntry)
    |=> timerOption[`OPT_GIE] == $past(timerOption[`OPT_GIE]);
  endproperty
  a_gie_keep: assert property (p_gie_keep)
    else $error("option write changed interrupt enable");

  property p_timer_direct;
    @(posedge clk) disable iff (!resetn)
    (toWatchdog && !timerOption[`OPT_SOURCE] && running && !timerWrite)
    |=> timerCounter == 8'($past(timerCounter) + 8'h01);
  endproperty
  a_timer_direct: assert property (p_timer_direct)
    else $error("timer did not advance by one");

  property p_presc_clear;
    @(posedge clk) disable iff (!resetn)
    (timerWrite && !toWatchdog) |=> prescaler == 8'h00;
  endproperty
  a_presc_clear: assert property (p_presc_clear)
    else $error("prescaler not cleared by timer write");

  property p_wd_clear;
    @(posedge clk) disable iff (!resetn)
    watchdogClearInstr |=> watchdogTimer == 32'h0 && !watchdogReset;
  endproperty
  a_wd_clear: assert property (p_wd_clear)
    else $error("watchdog not cleared");

  property p_wd_fuse;
    @(posedge clk) disable iff (!resetn)
    !watchdogFuse [*2] |-> !watchdogReset;
  endproperty
  a_wd_fuse: assert property (p_wd_fuse)
    else $error("watchdog fired with fuse off");

  property p_dir_oe;
    @(posedge clk) disable iff (!resetn)
    ##1 port6Oe == ~$past(port6Direction);
  endproperty
  a_dir_oe: assert property (p_dir_oe)
    else $error("port 6 drive disagrees with direction");

  property p_sleep_enter;
    @(posedge clk) disable iff (!resetn)
    (running && $fell(watchdogSleepCtrl[`WD_SLEEP]))
    |-> ##1 !running ##1 oscStop;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter)
    else $error("oscillator not stopped after sleep bit fell");

  property p_wake_hold;
    @(posedge clk) disable iff (!resetn)
    $fell(oscStop) |-> coreHold [*3];
  endproperty
  a_wake_hold: assert property (p_wake_hold)
    else $error("core released without start-up delay");

  property p_ovf_sticky;
    @(posedge clk) disable iff (!resetn)
    (irqFlags[`IRQ_OVF] && !(regWrite && regSel == `SEL_IRQFLAG))
    |=> irqFlags[`IRQ_OVF];
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky)
    else $error("overflow flag lost without a clear");

endmodule : timer_watchdog_port_ctrl
`default_nettype wire

/* bench/core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// core side: register moves and instruction strobes
module core_model (
  // clock
  input  wire logic       clk,
  // register access
  output logic            regWrite,
  output logic            regRead,
  output logic      [2:0] regSel,
  output logic      [7:0] wrData,
  input  wire logic [7:0] rdData,
  // instruction strobes
  output logic            irqOnInstr,
  output logic            irqOffInstr,
  output logic            irqReturnInstr,
  output logic            irqEntry,
  output logic            watchdogClearInstr,
  output logic            sleepInstr
);
  logic [5:0] strobes;
  assign {sleepInstr, watchdogClearInstr, irqEntry} = strobes[5:3];
  assign {irqReturnInstr, irqOffInstr, irqOnInstr} = strobes[2:0];
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regSel = 3'h0;
    wrData = 8'h00;
    strobes = 6'h00;
  end
  // released select and data lines show the inverse, never a stale match
  task automatic wr(input logic [2:0] sel, input logic [7:0] d);
    @(negedge clk);
    regSel = sel;
    wrData = d;
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
    regSel = ~sel;
    wrData = ~d;
  endtask : wr
  task automatic rd(input logic [2:0] sel, output logic [7:0] d);
    @(negedge clk);
    regSel = sel;
    regRead = 1'b1;
    @(negedge clk);
    regRead = 1'b0;
    regSel = ~sel;
    @(negedge clk);
    d = rdData;
  endtask : rd
  // k: 0 on, 1 off, 2 return, 3 entry, 4 watchdog clear, 5 sleep
  task automatic op(input int k);
    @(negedge clk);
    strobes[k] = 1'b1;
    @(negedge clk);
    strobes = 6'h00;
  endtask : op
endmodule : core_model
`default_nettype wire

/* bench/test_timer_watchdog_port_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tmr_cfg.svh"
module test_timer_watchdog_port_ctrl;
  // ==========
  // signals
  logic clk, resetn, regWrite, regRead;
  logic [2:0] regSel;
  logic [7:0] wrData, rdData;
  logic irqOnInstr, irqOffInstr, irqReturnInstr, irqEntry;
  logic watchdogClearInstr, sleepInstr, watchdogFuse;
  logic timerPin, extIrqPinN, pullupOn, wakeArmed;
  logic [7:0] port6Pins, port7Pins, port5Oe, port6Oe, port7Oe;
  logic [1:0] port7OdData, resistorOptionRead;
  logic irqRequest, watchdogReset, oscStop, coreHold;
  int errTotal, totalChecks;
  logic [31:0] seed;
  logic [7:0] rstVal [8] = '{8'hBF, 8'h0F, 8'hFF, 8'hFF,
                             8'h31, 8'h00, 8'h00, 8'h00};
  // ==========
  // design and core model
  timer_watchdog_port_ctrl #(.WDT_CYCLES(16), .OST_CYCLES(16),
                             .SMALL_VARIANT(1'b1)) i_dut (
    .clk(clk), .resetn(resetn), .regWrite(regWrite),
    .regRead(regRead), .regSel(regSel), .wrData(wrData),
    .rdData(rdData), .irqOnInstr(irqOnInstr),
    .irqOffInstr(irqOffInstr), .irqReturnInstr(irqReturnInstr),
    .irqEntry(irqEntry), .watchdogClearInstr(watchdogClearInstr),
    .sleepInstr(sleepInstr), .watchdogFuse(watchdogFuse),
    .timerPin(timerPin), .extIrqPinN(extIrqPinN),
    .port6Pins(port6Pins), .port7Pins(port7Pins),
    .port7OdData(port7OdData), .port5Oe(port5Oe), .port6Oe(port6Oe),
    .port7Oe(port7Oe), .pullupOn(pullupOn), .wakeArmed(wakeArmed),
    .resistorOptionRead(resistorOptionRead), .irqRequest(irqRequest),
    .watchdogReset(watchdogReset), .oscStop(oscStop),
    .coreHold(coreHold));
  core_model i_core (
    .clk(clk), .regWrite(regWrite), .regRead(regRead),
    .regSel(regSel), .wrData(wrData), .rdData(rdData),
    .irqOnInstr(irqOnInstr), .irqOffInstr(irqOffInstr),
    .irqReturnInstr(irqReturnInstr), .irqEntry(irqEntry),
    .watchdogClearInstr(watchdogClearInstr), .sleepInstr(sleepInstr));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ==========
  // helpers
  function automatic logic [7:0] nxt();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : nxt
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic endSim();
    if (errTotal == 0 && totalChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : endSim
  task automatic rdChk(input logic [2:0] sel, input logic [7:0] exp);
    logic [7:0] v;
    i_core.rd(sel, v);
    check({24'h0, v}, {24'h0, exp});
  endtask : rdChk
  // counts cycles until the time-out pulse; a missing pulse is fatal when must is set
  task automatic waitWd(input int lim, input bit must, output int n);
    n = 0;
    while (watchdogReset !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (must && n >= lim) begin
      errTotal++;
      endSim();
    end
  endtask : waitWd
  // ==========
  // main sequence
  initial begin
    int i, n, d;
    logic [7:0] v, w, r;
    logic [7:0] dirs [4];
    seed = 32'h2b9ccc64;
    errTotal = 0;
    totalChecks = 0;
    resetn = 1'b0;
    watchdogFuse = 1'b0;
    timerPin = 1'b0;
    extIrqPinN = 1'b1;
    port6Pins = 8'hFF;
    port7Pins = 8'hFF;
    port7OdData = 2'b00;
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    check({port5Oe, port6Oe, port7Oe}, 24'h0);
    check({pullupOn, wakeArmed}, 2'b00);
    for (i = 0; i < 8; i++) rdChk(i[2:0], rstVal[i]);
    // directions, random per port
    for (i = 1; i < 4; i++) begin
      dirs[i] = nxt();
      i_core.wr(i[2:0], dirs[i]);
      rdChk(i[2:0], (i == 1) ? (dirs[i] & 8'h0F) : dirs[i]);
    end
    check(port5Oe, 8'(~(dirs[1] | 8'hF0)));
    check(port6Oe, 8'(~dirs[2]));
    check(port7Oe, 8'(~dirs[3]));
    i_core.wr(`SEL_WDCTRL, 8'h51);
    for (i = 0; i < 4; i++) begin
      @(negedge clk);
      port7OdData = i[1:0];
      repeat (3) @(negedge clk);
      check(port7Oe, {~dirs[3][7:6] & ~i[1:0], ~dirs[3][5:0]});
    end
    rdChk(`SEL_WDCTRL, 8'h51);
    i_core.wr(`SEL_WDCTRL, 8'h31);
    // pull-ups and interrupt enable
    i_core.wr(`SEL_OPTION, 8'h08);
    repeat (2) @(negedge clk);
    check(pullupOn, 1'b1);
    i_core.wr(`SEL_OPTION, 8'hC8);
    rdChk(`SEL_OPTION, 8'h88);
    check(pullupOn, 1'b0);
    for (i = 0; i < 4; i++) begin
      v = (i % 2 == 0) ? 8'hC8 : 8'h88;
      i_core.op(i);
      rdChk(`SEL_OPTION, v);
      i_core.wr(`SEL_OPTION, (~v & 8'h40) | 8'h88);
      rdChk(`SEL_OPTION, v);
    end
    // flags and mask
    i_core.wr(`SEL_IRQMASK, 8'hFF);
    rdChk(`SEL_IRQMASK, 8'h09);
    i_core.wr(`SEL_TIMER, 8'hFF);
    repeat (4) @(negedge clk);
    rdChk(`SEL_IRQFLAG, 8'h01);
    extIrqPinN = ~extIrqPinN;
    repeat (4) @(negedge clk);
    rdChk(`SEL_IRQFLAG, 8'h09);
    check(irqRequest, 1'b0);
    i_core.op(0);
    repeat (3) @(negedge clk);
    check(irqRequest, 1'b1);
    i_core.wr(`SEL_IRQMASK, 8'h01);
    rdChk(`SEL_IRQFLAG, 8'h01);
    i_core.wr(`SEL_IRQMASK, 8'h00);
    rdChk(`SEL_IRQFLAG, 8'h00);
    check(irqRequest, 1'b0);
    i_core.wr(`SEL_IRQMASK, 8'h09);
    i_core.wr(`SEL_IRQFLAG, 8'h08);
    rdChk(`SEL_IRQFLAG, 8'h08);
    i_core.wr(`SEL_IRQFLAG, 8'h00);
    rdChk(`SEL_IRQFLAG, 8'h00);
    extIrqPinN = ~extIrqPinN;
    // timer rate: reads spaced by two prescaler periods, or by eight cycles with the timer unprescaled
    for (n = 0; n < 9; n++) begin
      d = (n == 8) ? 8 : (4 << n);
      i_core.wr(`SEL_OPTION, (n == 8) ? 8'h88 : (8'h80 | n[7:0]));
      i_core.rd(`SEL_TIMER, v);
      repeat (d - 3) @(negedge clk);
      i_core.rd(`SEL_TIMER, w);
      r = w - v;
      check(r, (n == 8) ? 8'h08 : 8'h02);
    end
    i_core.wr(`SEL_OPTION, 8'h87);
    for (i = 0; i < 3; i++) begin
      i_core.wr(`SEL_TIMER, 8'h55);
      repeat (100) @(negedge clk);
    end
    rdChk(`SEL_TIMER, 8'h55);
    // external pin, both edge selections
    for (i = 0; i < 2; i++) begin
      i_core.wr(`SEL_OPTION, i[0] ? 8'hB8 : 8'hA8);
      i_core.rd(`SEL_TIMER, v);
      timerPin = ~timerPin;
      repeat (6) @(negedge clk);
      i_core.rd(`SEL_TIMER, w);
      r = w - v;
      check(r, i[0] ? 8'h00 : 8'h01);
      timerPin = ~timerPin;
      repeat (6) @(negedge clk);
      i_core.rd(`SEL_TIMER, v);
      r = v - w;
      check(r, i[0] ? 8'h01 : 8'h00);
    end
    // resistor option
    i_core.wr(`SEL_WDCTRL, 8'h19);
    for (i = 0; i < 4; i++) begin
      w = nxt();
      port6Pins = w;
      port7Pins = {w[7:2], i[1:0]};
      repeat (4) @(negedge clk);
      check(resistorOptionRead, i[1:0]);
    end
    i_core.wr(`SEL_WDCTRL, 8'h11);
    repeat (3) @(negedge clk);
    check(resistorOptionRead, 2'b00);
    port6Pins = 8'hFF;
    port7Pins = 8'hFF;
    // watchdog
    watchdogFuse = 1'b1;
    i_core.wr(`SEL_OPTION, 8'h80);
    i_core.wr(`SEL_WDCTRL, 8'h31);
    for (i = 0; i < 10; i++) begin
      i_core.op(4 + i % 2);
      waitWd(8, 1'b0, n);
      check(n, 8);
    end
    i_core.op(4);
    waitWd(100, 1'b1, n);
    check(n >= 12 && n <= 20, 1'b1);
    i_core.wr(`SEL_OPTION, 8'h8A);
    i_core.op(5);
    waitWd(200, 1'b1, n);
    check(n >= 60 && n <= 68, 1'b1);
    i_core.wr(`SEL_WDCTRL, 8'h11);
    i_core.op(4);
    waitWd(150, 1'b0, n);
    check(n, 150);
    watchdogFuse = 1'b0;
    i_core.wr(`SEL_WDCTRL, 8'h31);
    i_core.op(4);
    waitWd(150, 1'b0, n);
    check(n, 150);
    // oscillator stop and pin wake-up
    for (i = 0; i < 2; i++) begin
      watchdogFuse = ~i[0];
      i_core.wr(`SEL_WDCTRL, 8'h10);
      repeat (2) @(negedge clk);
      check(wakeArmed, 1'b1);
      i_core.wr(`SEL_WDCTRL, 8'h00);
      repeat (3) @(negedge clk);
      check({oscStop, coreHold}, 2'b11);
      if (i == 0) port6Pins[3] = 1'b0;
      else port7Pins[4] = 1'b0;
      n = 0;
      while (coreHold !== 1'b0 && n < 100) begin
        @(negedge clk);
        n++;
      end
      if (n >= 100) begin
        errTotal++;
        endSim();
      end
      check(n >= 16 && n <= 30, 1'b1);
      check(oscStop, 1'b0);
      rdChk(`SEL_WDCTRL, i[0] ? 8'h10 : 8'h30);
      port6Pins = 8'hFF;
      port7Pins = 8'hFF;
    end
    endSim();
  end
endmodule : test_timer_watchdog_port_ctrl
`default_nettype wire
